// [dbr_host.sv]
// host processor model making single-byte register accesses
module dbr_host
	import dbr_pkg::*;
(
	// clock
	input wire logic clk,
	// register port
	output dbr_bus_t req,
	input wire logic [7:0] rdData,
	input wire logic rdValid
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req = '{1'b0, 1'b0, 5'h1f, 8'h00};
	// released lines flip so a stale value never looks valid
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(negedge clk);
		req <= '{1'b1, 1'b0, a, d};
		@(negedge clk);
		req <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [4:0] a, output logic [7:0] d,
		output logic v);
		@(negedge clk);
		req <= '{1'b0, 1'b1, a, ~req.data};
		@(negedge clk);
		d = rdData;
		v = rdValid;
		req <= '{1'b0, 1'b0, ~a, ~req.data};
	endtask : rd
	// two byte writes on back-to-back cycles, as a 16-bit move
	task automatic wr2(input logic [4:0] a0, input logic [7:0] d0,
		input logic [4:0] a1, input logic [7:0] d1);
		@(negedge clk);
		req <= '{1'b1, 1'b0, a0, d0};
		@(negedge clk);
		req <= '{1'b1, 1'b0, a1, d1};
		@(negedge clk);
		req <= '{1'b0, 1'b0, ~a1, ~d1};
	endtask : wr2
	// read strobe held for two edges gives two byte reads in a row
	task automatic rd2(input logic [4:0] a, output logic [7:0] d0, d1,
		output logic v0, v1);
		@(negedge clk);
		req <= '{1'b0, 1'b1, a, ~req.data};
		@(negedge clk);
		d0 = rdData;
		v0 = rdValid;
		@(negedge clk);
		d1 = rdData;
		v1 = rdValid;
		req <= '{1'b0, 1'b0, ~a, ~req.data};
	endtask : rd2
endmodule : dbr_host

// [dbr_pkg.sv]
// constants, types and register map of the board register decode
// Notes on behaviour
// RULE_01 - after reset the input path is grounded single-ended with the bipolar 5 V range.
// RULE_02 - software picks the input range (bipolar or unipolar) and the input mode (grounded, floating or paired).
// RULE_03 - both output channels start bipolar and software may make each one unipolar.
// RULE_04 - twenty-four digital lines form three ports that all come up as mode 0 inputs.
// RULE_05 - every register is one byte and sixteen-bit values move as two byte accesses.
// RULE_06 - the first read of a sample returns its low byte and the second its high byte.
// RULE_07 - offset 00 is the first control word on a write and the first status byte on a read.
// RULE_08 - any write to offset 03 starts one conversion.
// RULE_09 - offset 08 flushes the sample queue on a write and offset 0a reads the queue.
// RULE_10 - each output channel is loaded by a low and a high byte at offsets 04 to 07.
// RULE_11 - counter group A has three read-write data bytes at 14 to 16 and a setup byte at 17.
// RULE_12 - strobe locations act on any write and ignore the data.
// RULE_13 - all control words are zero after reset.
// RULE_14 - reads of write-only offsets have no side effect and return a value to ignore; a read of offset 17 still loads ctrAddr.
package dbr_pkg;
	localparam logic [4:0] OFS_CW1 = 5'h00;
	localparam logic [4:0] OFS_STAT1 = 5'h00;
	localparam logic [4:0] OFS_CW2 = 5'h01;
	localparam logic [4:0] OFS_CW3 = 5'h02;
	localparam logic [4:0] OFS_TRIG = 5'h03;
	localparam logic [4:0] OFS_OUT0_LO = 5'h04;
	localparam logic [4:0] OFS_OUT0_HI = 5'h05;
	localparam logic [4:0] OFS_OUT1_LO = 5'h06;
	localparam logic [4:0] OFS_OUT1_HI = 5'h07;
	localparam logic [4:0] OFS_FLUSH = 5'h08;
	localparam logic [4:0] OFS_QDATA = 5'h0a;
	localparam logic [4:0] OFS_CW6 = 5'h0e;
	localparam logic [4:0] OFS_CW4 = 5'h0f;
	localparam logic [4:0] OFS_PORTA = 5'h10;
	localparam logic [4:0] OFS_PORTB = 5'h11;
	localparam logic [4:0] OFS_PORTC = 5'h12;
	localparam logic [4:0] OFS_PCTRL = 5'h13;
	localparam logic [4:0] OFS_CNT0 = 5'h14;
	localparam logic [4:0] OFS_CNT2 = 5'h16;
	localparam logic [4:0] OFS_CSETUP = 5'h17;
	localparam logic [4:0] OFS_CW5 = 5'h1c;
	localparam logic [4:0] OFS_STAT2 = 5'h1d;
	localparam logic [7:0] CW_RESET = 8'h00;
	localparam logic [7:0] PCTRL_RESET = 8'h9b;
	localparam int CW4_MODE_LSB = 0;
	localparam int CW2_INUNI_BIT = 0;
	localparam int CW2_OUT0UNI_BIT = 1;
	localparam int CW2_OUT1UNI_BIT = 2;
	localparam int PCTRL_SET_BIT = 7;
	localparam int PCTRL_A_BIT = 4;
	localparam int PCTRL_CHI_BIT = 3;
	localparam int PCTRL_B_BIT = 1;
	localparam int PCTRL_CLO_BIT = 0;
	localparam int ADC_W = 12;
	localparam int Q_AW = 4;
	localparam int Q_DEPTH = 16;
	localparam logic [Q_AW:0] Q_FULL = 5'h10;
	typedef enum logic [1:0] {
		GROUNDED_SINGLE_ENDED,
		FLOATING_SINGLE_ENDED,
		PAIRED_INPUT_MODE
	} dbr_in_mode_t;
	typedef struct packed {
		dbr_in_mode_t mode;
		logic inUni;
		logic out0Uni;
		logic out1Uni;
	} dbr_acfg_t;
	localparam dbr_acfg_t CFG_RESET = '{GROUNDED_SINGLE_ENDED, 1'b0, 1'b0, 1'b0};
	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [7:0] data;
	} dbr_bus_t;
	typedef struct packed {
		logic [7:0] one;
		logic [7:0] two;
		logic [7:0] three;
		logic [7:0] four;
		logic [7:0] five;
		logic [7:0] six;
	} dbr_cmd_t;
endpackage : dbr_pkg

// [dbr_regs.sv]
// host register decode, sample queue and startup defaults of the board
module dbr_regs
	import dbr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// host byte access
	input dbr_bus_t hostReq,
	output logic [7:0] rdData,
	output logic rdValid,
	// converter
	output logic adcStart,
	input wire logic [ADC_W-1:0] adcResult,
	input wire logic adcDone,
	// output channels
	output logic [ADC_W-1:0] out0Value,
	output logic out0Load,
	output logic [ADC_W-1:0] out1Value,
	output logic out1Load,
	// configuration
	output dbr_acfg_t aCfg,
	output dbr_cmd_t cmdWords,
	// counter group a
	output logic ctrWr,
	output logic ctrRd,
	output logic [1:0] ctrAddr,
	output logic [7:0] ctrWrData,
	input wire logic [7:0] ctrCount [3],
	// digital ports
	input wire logic [23:0] portIn,
	output logic [23:0] portOut,
	output logic [23:0] portOe_n
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic wrTaken, rdTaken;
	logic [4:0] a;
	logic [7:0] d;
	assign wrTaken = hostReq.wr;
	// a write in the same cycle wins; the read is dropped
	assign rdTaken = hostReq.rd & ~hostReq.wr;
	assign a = hostReq.addr;
	assign d = hostReq.data;

	function automatic dbr_in_mode_t modeOf(input logic [1:0] c);
		case (c)
			2'h1: return FLOATING_SINGLE_ENDED;
			2'h2: return PAIRED_INPUT_MODE;
			default: return GROUNDED_SINGLE_ENDED;
		endcase
	endfunction : modeOf

	function automatic logic [23:0] dirOf(input logic [7:0] c);
		return {{4{c[PCTRL_CHI_BIT]}}, {4{c[PCTRL_CLO_BIT]}},
			{8{c[PCTRL_B_BIT]}}, {8{c[PCTRL_A_BIT]}}};
	endfunction : dirOf

	// control words
	dbr_cmd_t cmd_reg;
	dbr_acfg_t cfg_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			cmd_reg <= {6{CW_RESET}}; // RULE_13
		end else if (wrTaken) begin
			case (a)
				OFS_CW1: cmd_reg.one <= d; // RULE_07
				OFS_CW2: cmd_reg.two <= d;
				OFS_CW3: cmd_reg.three <= d;
				OFS_CW4: cmd_reg.four <= d;
				OFS_CW5: cmd_reg.five <= d;
				OFS_CW6: cmd_reg.six <= d;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg <= CFG_RESET; // RULE_01 RULE_03
		end else if (wrTaken && a == OFS_CW4) begin
			cfg_reg.mode <= modeOf(d[CW4_MODE_LSB +: 2]); // RULE_02
		end else if (wrTaken && a == OFS_CW2) begin
			cfg_reg.inUni <= d[CW2_INUNI_BIT]; // RULE_02
			cfg_reg.out0Uni <= d[CW2_OUT0UNI_BIT]; // RULE_03
			cfg_reg.out1Uni <= d[CW2_OUT1UNI_BIT]; // RULE_03
		end
	end
	assign cmdWords = cmd_reg;
	assign aCfg = cfg_reg;

	// strobes ignore the data byte
	logic adcStart_reg, flush;
	assign flush = wrTaken && a == OFS_FLUSH; // RULE_09 RULE_12
	always_ff @(posedge clk) begin
		if (rst) begin
			adcStart_reg <= 1'b0;
		end else begin
			adcStart_reg <= wrTaken && a == OFS_TRIG; // RULE_08 RULE_12
		end
	end
	assign adcStart = adcStart_reg;

	// output channels: low byte waits, high byte loads the pair
	logic [7:0] low0_reg, low1_reg;
	logic [ADC_W-1:0] out0Value_reg, out1Value_reg;
	logic out0Load_reg, out1Load_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			low0_reg <= 8'h00;
			low1_reg <= 8'h00;
			out0Value_reg <= 12'h000;
			out1Value_reg <= 12'h000;
			out0Load_reg <= 1'b0;
			out1Load_reg <= 1'b0;
		end else begin
			out0Load_reg <= wrTaken && a == OFS_OUT0_HI; // RULE_10
			out1Load_reg <= wrTaken && a == OFS_OUT1_HI; // RULE_10
			if (wrTaken && a == OFS_OUT0_LO) low0_reg <= d;
			if (wrTaken && a == OFS_OUT1_LO) low1_reg <= d;
			if (wrTaken && a == OFS_OUT0_HI) begin
				out0Value_reg <= {d[3:0], low0_reg}; // RULE_05
			end
			if (wrTaken && a == OFS_OUT1_HI) begin
				out1Value_reg <= {d[3:0], low1_reg}; // RULE_05
			end
		end
	end
	assign out0Value = out0Value_reg;
	assign out1Value = out1Value_reg;
	assign out0Load = out0Load_reg;
	assign out1Load = out1Load_reg;

	// counter group a: bytes pass through to the counter device
	logic ctrWr_reg, ctrRd_reg;
	logic [1:0] ctrAddr_reg;
	logic [7:0] ctrWrData_reg;
	logic ctrHit;
	assign ctrHit = a >= OFS_CNT0 && a <= OFS_CSETUP;
	always_ff @(posedge clk) begin
		if (rst) begin
			ctrWr_reg <= 1'b0;
			ctrRd_reg <= 1'b0;
			ctrAddr_reg <= 2'h0;
			ctrWrData_reg <= 8'h00;
		end else begin
			ctrWr_reg <= wrTaken && ctrHit; // RULE_11
			// the setup byte is write-only, so no read pulse for it
			ctrRd_reg <= rdTaken && ctrHit && a != OFS_CSETUP; // RULE_11
			if ((wrTaken || rdTaken) && ctrHit) begin
				ctrAddr_reg <= a[1:0];
			end
			if (wrTaken && ctrHit) ctrWrData_reg <= d;
		end
	end
	assign ctrWr = ctrWr_reg;
	assign ctrRd = ctrRd_reg;
	assign ctrAddr = ctrAddr_reg;
	assign ctrWrData = ctrWrData_reg;

	// digital ports, mode 0 only
	logic [23:0] portMeta_reg, portSync_reg, portOut_reg, portOe_n_reg;
	logic [7:0] pctrl_reg;
	always_ff @(posedge clk) begin
		if (rst) begin
			portMeta_reg <= 24'h000000;
			portSync_reg <= 24'h000000;
		end else begin
			portMeta_reg <= portIn;
			portSync_reg <= portMeta_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			pctrl_reg <= PCTRL_RESET; // RULE_04
			portOe_n_reg <= dirOf(PCTRL_RESET); // RULE_04
			portOut_reg <= 24'h000000;
		end else if (wrTaken && a == OFS_PCTRL && d[PCTRL_SET_BIT]) begin
			// a mode set also clears the output latches
			pctrl_reg <= d;
			portOe_n_reg <= dirOf(d);
			portOut_reg <= 24'h000000;
		end else if (wrTaken && a >= OFS_PORTA && a <= OFS_PORTC) begin
			portOut_reg[8*a[1:0] +: 8] <= d;
		end
	end
	assign portOut = portOut_reg;
	assign portOe_n = portOe_n_reg;

	// sample queue
	logic [ADC_W-1:0] qMem [Q_DEPTH];
	logic [Q_AW-1:0] qWr_reg, qRd_reg;
	logic [Q_AW:0] qCount_reg;
	logic highPhase_reg, overflow_reg, busy_reg;
	logic qEmpty, qFull, push, pop, qRead;
	logic [ADC_W-1:0] head;
	assign qEmpty = qCount_reg == '0;
	assign qFull = qCount_reg == Q_FULL;
	assign head = qMem[qRd_reg];
	assign qRead = rdTaken && a == OFS_QDATA; // RULE_09
	assign push = adcDone && (flush || !qFull);
	assign pop = qRead && highPhase_reg && !qEmpty && !flush; // RULE_06
	always_ff @(posedge clk) begin
		if (push) qMem[flush ? '0 : qWr_reg] <= adcResult;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			qWr_reg <= '0;
			qRd_reg <= '0;
			qCount_reg <= '0;
		end else if (flush) begin
			// a sample landing during the flush is kept
			qRd_reg <= '0;
			qWr_reg <= push ? Q_AW'(1) : '0;
			qCount_reg <= push ? (Q_AW+1)'(1) : '0; // RULE_09
		end else begin
			if (push) qWr_reg <= qWr_reg + 1'b1;
			if (pop) qRd_reg <= qRd_reg + 1'b1;
			qCount_reg <= qCount_reg + {4'h0, push} - {4'h0, pop};
		end
	end

	always_ff @(posedge clk) begin
		if (rst || flush) begin
			highPhase_reg <= 1'b0;
		end else if (qRead && !qEmpty) begin
			highPhase_reg <= !highPhase_reg; // RULE_05 RULE_06
		end
	end

	// busy: a start in the done cycle wins; overflow: a flush in the set cycle wins
	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			overflow_reg <= (adcDone && qFull && !flush)
				|| (overflow_reg && !flush);
			busy_reg <= adcStart_reg || (busy_reg && !adcDone);
		end
	end

	// read side; write-only offsets answer zero and touch nothing except ctrAddr, which a setup byte read still loads
	logic [7:0] status1, status2, rdNext, portView;
	logic [7:0] rdData_reg;
	logic rdValid_reg;
	assign status1 = {5'h00, busy_reg, overflow_reg, !qEmpty};
	assign status2 = {6'h00, qFull, highPhase_reg};
	assign portView = (portOe_n_reg[8*a[1:0] +: 8] & portSync_reg[8*a[1:0] +: 8])
		| (~portOe_n_reg[8*a[1:0] +: 8] & portOut_reg[8*a[1:0] +: 8]);
	always_comb begin
		rdNext = 8'h00; // RULE_14
		case (a)
			OFS_STAT1: rdNext = status1; // RULE_07
			OFS_STAT2: rdNext = status2;
			OFS_QDATA: begin
				if (qEmpty) rdNext = 8'h00;
				else if (highPhase_reg) rdNext = {4'h0, head[11:8]}; // RULE_06
				else rdNext = head[7:0]; // RULE_06
			end
			OFS_PORTA, OFS_PORTB, OFS_PORTC: rdNext = portView;
			default: begin
				if (ctrHit && a != OFS_CSETUP) rdNext = ctrCount[a[1:0]]; // RULE_11
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData_reg <= 8'h00;
			rdValid_reg <= 1'b0;
		end else begin
			rdValid_reg <= rdTaken;
			if (rdTaken) rdData_reg <= rdNext;
		end
	end
	assign rdData = rdData_reg;
	assign rdValid = rdValid_reg;

	// checks
	sequence lowRead;
		qRead && !qEmpty && !highPhase_reg && !flush;
	endsequence
	sequence highRead;
		rdTaken && a == OFS_QDATA;
	endsequence

	a_startup_defaults: assert property ($fell(rst) |-> // RULE_01
		aCfg == CFG_RESET && !aCfg.out0Uni && !aCfg.out1Uni)
		else $error("input or output range not at default");
	a_ports_inputs: assert property ($fell(rst) |-> // RULE_04
		portOe_n == 24'hffffff && portOut == 24'h000000)
		else $error("ports not inputs after reset");
	a_cmd_cleared: assert property ($fell(rst) |-> cmdWords == '0) // RULE_13
		else $error("control words not cleared");
	a_mode_select: assert property (wrTaken && a == OFS_CW4 |=> // RULE_02
		aCfg.mode == modeOf($past(d[1:0])))
		else $error("input mode not taken from control word");
	a_trigger_pulse: assert property ( // RULE_08
		adcStart == $past(wrTaken && a == OFS_TRIG))
		else $error("start pulse does not match trigger write");
	a_dac_pair: assert property (wrTaken && a == OFS_OUT0_LO ##1 // RULE_10
		(wrTaken && a == OFS_OUT0_HI) |=> out0Load &&
		out0Value == {$past(d[3:0]), $past(d, 2)})
		else $error("output channel zero not loaded from byte pair");
	a_low_first: assert property (lowRead |=> // RULE_06
		rdValid && rdData == $past(head[7:0]))
		else $error("first sample byte is not the low byte");
	a_high_second: assert property (lowRead ##1 highRead |=> // RULE_06
		rdData == {4'h0, $past(head[11:8])} && qCount_reg <= $past(qCount_reg, 2))
		else $error("second sample byte is not the high byte");
	a_status_read: assert property (rdTaken && a == OFS_STAT1 |=> // RULE_07
		rdData == $past(status1))
		else $error("offset zero read does not give status");
	a_flush_empty: assert property (flush && !adcDone |=> // RULE_09
		qEmpty && !highPhase_reg)
		else $error("flush left samples behind");
	a_wo_silent: assert property (rdTaken && a == OFS_OUT0_LO |=> // RULE_14
		rdData == 8'h00 && !out0Load && !ctrRd)
		else $error("write-only read had an effect");
	a_ctr_route: assert property (wrTaken && ctrHit |=> // RULE_11
		ctrWr && ctrAddr == $past(a[1:0]) && ctrWrData == $past(d))
		else $error("counter byte not passed on");
endmodule : dbr_regs

// [dbr_regs_end.sv]
// no logic here; the whole register decode sits in dbr_regs

// [tb.sv]
// self-checking bench of the board register decode
module tb
	import dbr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	dbr_bus_t hostReq;
	logic [7:0] rdData, ctrWrData, d;
	logic rdValid, adcStart, adcDone, out0Load, out1Load, ctrWr, ctrRd, v;
	logic [ADC_W-1:0] adcResult, out0Value, out1Value;
	dbr_acfg_t aCfg;
	dbr_cmd_t cmdWords;
	logic [1:0] ctrAddr;
	logic [7:0] d1;
	logic v1;
	logic [7:0] ctrCount [3];
	logic [23:0] portIn, portOut, portOe_n;
	int n_mismatch = 0;
	int checks_done = 0;
	int cycles = 0;
	int q[$];
	always #10 clk = ~clk;
	dbr_host host_u (.clk, .req(hostReq), .rdData, .rdValid);
	dbr_regs dut_u (.clk, .rst, .hostReq, .rdData, .rdValid, .adcStart,
		.adcResult, .adcDone, .out0Value, .out0Load, .out1Value, .out1Load,
		.aCfg, .cmdWords, .ctrWr, .ctrRd, .ctrAddr, .ctrWrData, .ctrCount,
		.portIn, .portOut, .portOe_n);
	task automatic chk(input string nm, input logic [47:0] e, g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic rdchk(input logic [4:0] a, input logic [7:0] e);
		host_u.rd(a, d, v);
		chk("rdValid", 48'h1, {47'h0, v});
		chk("rdData", {40'h0, e}, {40'h0, d});
	endtask : rdchk
	// queue model keeps the 12-bit results in push order
	task automatic push(input int r);
		@(negedge clk);
		adcDone = 1'b1;
		adcResult = r[11:0];
		q.push_back(r & 'hfff);
		@(negedge clk);
		adcDone = 1'b0;
		adcResult = ~adcResult;
	endtask : push
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : give_verdict
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		int r;
		logic [7:0] b [6];
		logic [4:0] ofs [6];
		logic [4:0] wo [6];
		logic [1:0] m;
		ofs = '{OFS_CW1, OFS_CW2, OFS_CW3, OFS_CW4, OFS_CW5, OFS_CW6};
		wo = '{OFS_CW2, OFS_CW3, OFS_TRIG, OFS_OUT0_LO, OFS_FLUSH, OFS_CSETUP};
		r = $urandom(67);
		adcDone = 1'b0;
		adcResult = '0;
		portIn = 24'($urandom);
		ctrCount = '{8'h00, 8'h00, 8'h00};
		repeat (4) @(negedge clk);
		rst = 1'b0;
		chk("aCfg", 48'(CFG_RESET), 48'(aCfg));
		chk("cmdWords", 48'h0, cmdWords);
		chk("portOe_n", 48'hffffff, 48'(portOe_n));
		chk("portOut", 48'h0, 48'(portOut));
		rdchk(OFS_STAT1, 8'h00);
		$display("test reset done");
		foreach (b[i]) begin
			b[i] = 8'($urandom);
			host_u.wr(ofs[i], b[i]);
		end
		chk("cmdWords", {b[0], b[1], b[2], b[3], b[4], b[5]}, cmdWords);
		rdchk(OFS_STAT1, 8'h00);
		for (int i = 0; i < 4; i++) begin
			m = 2'(i);
			b[1] = 8'($urandom);
			host_u.wr(OFS_CW4, {6'($urandom), m});
			host_u.wr(OFS_CW2, b[1]);
			chk("aCfg", {43'h0, m == 2'h3 ? 2'h0 : m, b[1][0], b[1][1],
				b[1][2]}, 48'(aCfg));
		end
		$display("test control words done");
		foreach (ofs[i]) host_u.wr(ofs[i], 8'h00);
		for (int i = 0; i < 2; i++) begin
			host_u.wr(OFS_TRIG, i ? 8'hff : 8'h00);
			chk("adcStart", 48'h1, {47'h0, adcStart});
			@(negedge clk);
			chk("adcStart", 48'h0, {47'h0, adcStart});
		end
		rdchk(OFS_STAT1, 8'h04);
		$display("test trigger done");
		repeat (3) push($urandom);
		rdchk(OFS_STAT1, 8'h01);
		while (q.size() > 0) begin
			r = q.pop_front();
			host_u.rd2(OFS_QDATA, d, d1, v, v1);
			chk("rdValid", 48'h1, {47'h0, v});
			chk("rdData", {40'h0, r[7:0]}, {40'h0, d});
			chk("rdValid", 48'h1, {47'h0, v1});
			chk("rdData", {44'h0, r[11:8]}, {40'h0, d1});
		end
		push($urandom);
		rdchk(OFS_QDATA, 8'(q[0]));
		host_u.wr(OFS_FLUSH, 8'($urandom));
		q.delete();
		rdchk(OFS_QDATA, 8'h00);
		push($urandom);
		rdchk(OFS_QDATA, 8'(q[0]));
		host_u.wr(OFS_FLUSH, 8'h00);
		q.delete();
		rdchk(OFS_STAT1, 8'h00);
		$display("test queue done");
		for (int i = 0; i < 2; i++) begin
			b[0] = 8'($urandom);
			b[1] = 8'($urandom);
			if (i == 0) begin
				host_u.wr2(OFS_OUT0_LO, b[0], OFS_OUT0_HI, b[1]);
			end else begin
				host_u.wr(OFS_OUT1_LO, b[0]);
				host_u.wr(OFS_OUT1_HI, b[1]);
			end
			chk("load", 48'h1, {47'h0, i ? out1Load : out0Load});
			chk("idle load", 48'h0, {47'h0, i ? out0Load : out1Load});
			chk("value", {36'h0, b[1][3:0], b[0]},
				{36'h0, i ? out1Value : out0Value});
		end
		$display("test outputs done");
		for (int i = 0; i < 4; i++) begin
			b[0] = 8'($urandom);
			host_u.wr(5'(OFS_CNT0 + i), b[0]);
			chk("ctrWr", 48'h1, {47'h0, ctrWr});
			chk("ctr", {38'h0, 2'(i), b[0]}, {38'h0, ctrAddr, ctrWrData});
		end
		for (int i = 0; i < 3; i++) begin
			ctrCount[i] = 8'($urandom);
			rdchk(5'(OFS_CNT0 + i), ctrCount[i]);
			chk("ctrRd", 48'h1, {47'h0, ctrRd});
		end
		$display("test counters done");
		rdchk(OFS_PORTA, portIn[7:0]);
		host_u.wr(OFS_PCTRL, 8'h80);
		chk("portOe_n", 48'h0, 48'(portOe_n));
		b[0] = 8'($urandom);
		host_u.wr(OFS_PORTB, b[0]);
		chk("portOut", {32'h0, b[0], 8'h00}, 48'(portOut));
		rdchk(OFS_PORTB, b[0]);
		$display("test ports done");
		foreach (wo[i]) begin
			rdchk(wo[i], 8'h00);
			chk("adcStart", 48'h0, {47'h0, adcStart});
		end
		$display("test write-only reads done");
		give_verdict();
	end
endmodule : tb
